// ===== wp_ctrl_cfg.svh
// How it works
// - legacy mode: array writes blocked inside region chosen by block-protect bits
// - enhanced mode: array protection comes from the partition registers
// - partition registers are ignored unless enhanced mode is selected
// - status and partition writes blocked only if write-protect pin low whole frame
// - a started internal write always completes, whatever the write-protect pin does
// - write-protect pin ignored while pin-protect enable is zero, honoured when one
// - freeze ignored when pin-protect enable set and write-protect pin low
// - freeze frame is opcode 37h, address AA40h, confirmation byte D2h
// - complete freeze frame starts a timed write at chip select rise
// - freeze completion clears both latches, fixes mode bit, sets frozen flag
// - freeze ignored once already frozen; device idles at chip select rise
// - freeze frame cut short of 32 bits starts no write
// - freeze leaves pin-protect enable and block-protect bits alone and writable
// - write enable latch must be set before every write-type instruction
// - set-write-latch opcode 06h sets the latch at chip select rise
// - write enable latch cleared at reset, write completion, clear and soft reset
// - clear-write-latch opcode 04h clears the latch regardless of the pin
// - status is two bytes of nonvolatile bits and volatile latches
// - byte 0: enable bit 7, zeros 6..4, block-protect 3..2, latch 1, busy 0
// - block-protect 00 none, 01 upper quarter, 10 upper half, 11 all
// - busy reads one during an internal write, zero when ready
// - byte 1 bit 7 selects enhanced (1) or legacy (0, default) protection
// - partition latch set by partition write-enable, gates partition-type writes
// - while busy every frame is dropped; status and busy stay visible on the outputs
`ifndef WP_CTRL_CFG_SVH
`define WP_CTRL_CFG_SVH

`define OP_SET_WRITE_LATCH 8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_STATUS_WRITE 8'h01
`define OP_STATUS_READ 8'h05
`define OP_BUSY_POLL 8'h08
`define OP_PART_WRITE_ENABLE 8'h07
`define OP_PART_WRITE_DISABLE 8'h0a
`define OP_PART_WRITE 8'h32
`define OP_BOUNDARY_PROTECT 8'h34
`define OP_FREEZE 8'h37
`define OP_SOFT_RESET 8'h7c

`define FREEZE_ADDR 16'haa40
`define FREEZE_CONFIRM 8'hd2

`define BITS_OPCODE 6'h08
`define BITS_ONE_BYTE 6'h10
`define BITS_TWO_BYTES 6'h18
`define BITS_FULL 6'h20
`define BITS_MAX 6'h3f

`define S0_PIN_PROTECT_BIT 7
`define S0_BP_HI 3
`define S0_BP_LO 2
`define S1_MODE_BIT 7

`define RESET_PIN_PROTECT 1'b0
`define RESET_BLOCK_PROTECT 2'h0
`define RESET_MODE 1'b0

`define WRITE_TIME_NS 4000000
`define MCLK_PERIOD_NS 8

`endif

// ===== wp_ctrl_pkg.sv
package wp_ctrl_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} ctrl_state_t;

	typedef enum logic [2:0] {
		ACT_STATUS = 3'b001,
		ACT_PART = 3'b010,
		ACT_FREEZE = 3'b100
	} write_action_t;

	typedef struct packed {
		logic [7:0] op;
		logic [23:0] data;
		logic [5:0] count;
	} link_regs_t;

	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic wp_meta;
		logic wp_sync;
		logic wp_high_seen;
		ctrl_state_t state;
		write_action_t action;
		logic [19:0] timer;
		logic pin_protect_enable;
		logic [1:0] block_protect_field;
		logic write_enable_latch;
		logic partition_latch;
		logic protection_mode_select;
		logic config_frozen_flag;
		logic [7:0] pend_b0;
		logic [7:0] pend_b1;
		logic pend_two;
		logic [23:0] part_data;
		logic part_go;
	} core_regs_t;

endpackage : wp_ctrl_pkg

// ===== wp_ctrl.sv
`timescale 1ns/1ps
`include "wp_ctrl_cfg.svh"

module wp_ctrl
	import wp_ctrl_pkg::*;
#(
	parameter int WRITE_CYCLES = `WRITE_TIME_NS / `MCLK_PERIOD_NS
) (
	// system
	input wire logic mclk,
	input wire logic rstn,
	// serial link pins
	input wire logic link_sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic wp_n,
	// array write check
	input wire logic [11:0] array_addr,
	input wire logic partition_region_locked,
	output logic array_write_allowed,
	// status
	output logic [7:0] status_byte_zero,
	output logic [7:0] status_byte_one,
	output logic busy_flag,
	// partition register update
	output logic partition_write_go,
	output logic [23:0] partition_write_data
);

	link_regs_t link_q;
	link_regs_t link_d;
	logic frame_open_q;
	core_regs_t core_q;
	core_regs_t core_d;

	// true when the address falls in the block-protected region
	function automatic logic block_hit(input logic [1:0] bp, input logic [11:0] addr);
		case (bp)
			2'h0: block_hit = 1'b0;
			2'h1: block_hit = (addr[11:10] == 2'h3);
			2'h2: block_hit = addr[11];
			default: block_hit = 1'b1;
		endcase
	endfunction : block_hit

	// ---------------- link domain ----------------
	// cleared asynchronously by chip select high so the next frame restarts counting
	always_ff @(posedge link_sck or posedge cs_n) begin
		if (cs_n) begin
			frame_open_q <= 1'b0;
		end else begin
			frame_open_q <= 1'b1;
		end
	end

	always_comb begin
		link_d = link_q;
		if (!frame_open_q) begin
			link_d.op = {7'h00, si};
			link_d.data = 24'h000000;
			link_d.count = 6'h01;
		end else begin
			if (link_q.count < `BITS_OPCODE) begin
				link_d.op = {link_q.op[6:0], si};
			end else begin
				link_d.data = {link_q.data[22:0], si};
			end
			if (link_q.count != `BITS_MAX) begin
				link_d.count = link_q.count + 6'h01;
			end
		end
	end

	always_ff @(posedge link_sck or negedge rstn) begin
		if (!rstn) begin
			link_q <= '0;
		end else begin
			link_q <= link_d;
		end
	end

	// ---------------- core domain ----------------
	// link_q is read only after the synchronised chip select rise: the host
	// stops the serial clock between frames, so those bits stand still then
	logic frame_start;
	logic frame_end;
	logic hw_protect;
	logic [7:0] op;
	logic [5:0] cnt;
	logic [23:0] dat;
	logic freeze_ok;

	always_comb begin
		core_d = core_q;
		core_d.part_go = 1'b0;
		core_d.cs_meta = cs_n;
		core_d.cs_sync = core_q.cs_meta;
		core_d.cs_prev = core_q.cs_sync;
		core_d.wp_meta = wp_n;
		core_d.wp_sync = core_q.wp_meta;
		op = link_q.op;
		cnt = link_q.count;
		dat = link_q.data;
		frame_start = core_q.cs_prev & ~core_q.cs_sync;
		frame_end = ~core_q.cs_prev & core_q.cs_sync;
		if (frame_start) begin
			core_d.wp_high_seen = core_q.wp_sync;
		end else if (!core_q.cs_sync) begin
			core_d.wp_high_seen = core_q.wp_high_seen | core_q.wp_sync;
		end
		// pin counts only with the enable set and the pin low all frame
		hw_protect = core_q.pin_protect_enable & ~core_q.wp_high_seen;
		freeze_ok = (op == `OP_FREEZE) && (cnt == `BITS_FULL)
			&& (dat == {`FREEZE_ADDR, `FREEZE_CONFIRM})
			&& core_q.write_enable_latch && core_q.partition_latch
			&& !core_q.config_frozen_flag && !hw_protect;
		case (core_q.state)
			ST_IDLE: begin
				// frames while busy never reach here, so they are dropped
				if (frame_end) begin
					case (op)
						`OP_SET_WRITE_LATCH: begin
							if (cnt == `BITS_OPCODE) begin
								core_d.write_enable_latch = 1'b1;
							end
						end
						`OP_CLEAR_WRITE_LATCH: begin
							if (cnt == `BITS_OPCODE) begin
								core_d.write_enable_latch = 1'b0;
							end
						end
						`OP_SOFT_RESET: begin
							if (cnt == `BITS_OPCODE) begin
								core_d.write_enable_latch = 1'b0;
								core_d.partition_latch = 1'b0;
							end
						end
						`OP_PART_WRITE_ENABLE: begin
							if (cnt == `BITS_OPCODE && core_q.write_enable_latch) begin
								core_d.partition_latch = 1'b1;
							end
						end
						`OP_PART_WRITE_DISABLE: begin
							if (cnt == `BITS_OPCODE) begin
								core_d.partition_latch = 1'b0;
							end
						end
						`OP_STATUS_WRITE: begin
							if ((cnt == `BITS_ONE_BYTE || cnt == `BITS_TWO_BYTES)
								&& core_q.write_enable_latch && !hw_protect) begin
								core_d.pend_two = (cnt == `BITS_TWO_BYTES);
								core_d.pend_b0 = (cnt == `BITS_TWO_BYTES) ? dat[15:8] : dat[7:0];
								core_d.pend_b1 = dat[7:0];
								core_d.action = ACT_STATUS;
								core_d.timer = 20'(WRITE_CYCLES);
								core_d.state = ST_BUSY;
							end
						end
						`OP_PART_WRITE, `OP_BOUNDARY_PROTECT: begin
							if (cnt == `BITS_FULL && core_q.write_enable_latch
								&& core_q.partition_latch && !hw_protect
								&& !core_q.config_frozen_flag) begin
								core_d.part_data = dat;
								core_d.action = ACT_PART;
								core_d.timer = 20'(WRITE_CYCLES);
								core_d.state = ST_BUSY;
							end
						end
						`OP_FREEZE: begin
							if (freeze_ok) begin
								core_d.action = ACT_FREEZE;
								core_d.timer = 20'(WRITE_CYCLES);
								core_d.state = ST_BUSY;
							end
						end
						default: begin
						end
					endcase
				end
			end
			ST_BUSY: begin
				// the pin is not looked at here: a started write runs out
				if (core_q.timer > 20'h00001) begin
					core_d.timer = core_q.timer - 20'h00001;
				end else begin
					core_d.timer = 20'h00000;
					core_d.state = ST_IDLE;
					core_d.write_enable_latch = 1'b0;
					case (core_q.action)
						ACT_STATUS: begin
							core_d.pin_protect_enable = core_q.pend_b0[`S0_PIN_PROTECT_BIT];
							core_d.block_protect_field =
								core_q.pend_b0[`S0_BP_HI:`S0_BP_LO];
							if (core_q.pend_two && !core_q.config_frozen_flag) begin
								core_d.protection_mode_select = core_q.pend_b1[`S1_MODE_BIT];
							end
						end
						ACT_PART: begin
							core_d.part_go = 1'b1;
						end
						ACT_FREEZE: begin
							// mode bit keeps its value and is locked by the frozen flag
							core_d.config_frozen_flag = 1'b1;
							core_d.partition_latch = 1'b0;
						end
						default: begin
						end
					endcase
				end
			end
			default: begin
				core_d.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			core_q <= '0;
			core_q.cs_meta <= 1'b1;
			core_q.cs_sync <= 1'b1;
			core_q.cs_prev <= 1'b1;
			core_q.wp_meta <= 1'b1;
			core_q.wp_sync <= 1'b1;
			core_q.state <= ST_IDLE;
			core_q.action <= ACT_STATUS;
			core_q.pin_protect_enable <= `RESET_PIN_PROTECT;
			core_q.block_protect_field <= `RESET_BLOCK_PROTECT;
			core_q.protection_mode_select <= `RESET_MODE;
			core_q.write_enable_latch <= 1'b0;
		end else begin
			core_q <= core_d;
		end
	end

	// ---------------- outputs ----------------
	assign busy_flag = (core_q.state == ST_BUSY);

	always_comb begin
		status_byte_zero = 8'h00;
		status_byte_zero[`S0_PIN_PROTECT_BIT] = core_q.pin_protect_enable;
		status_byte_zero[`S0_BP_HI:`S0_BP_LO] = core_q.block_protect_field;
		status_byte_zero[1] = core_q.write_enable_latch;
		status_byte_zero[0] = busy_flag;
		status_byte_one = 8'h00;
		status_byte_one[`S1_MODE_BIT] = core_q.protection_mode_select;
		status_byte_one[5] = core_q.config_frozen_flag;
		status_byte_one[4] = core_q.partition_latch;
		status_byte_one[0] = busy_flag;
	end

	// enhanced mode uses only the partition verdict, legacy only the block bits
	assign array_write_allowed = core_q.write_enable_latch && !busy_flag
		&& (core_q.protection_mode_select ? !partition_region_locked
		: !block_hit(core_q.block_protect_field, array_addr));

	assign partition_write_go = core_q.part_go;
	assign partition_write_data = core_q.part_data;

endmodule : wp_ctrl

// ===== wp_ctrl_properties.sv
`timescale 1ns/1ps
module wp_ctrl_properties #(
	parameter int WRITE_CYCLES = 20
) (
	// system
	input wire logic mclk,
	input wire logic rstn,
	// link pins
	input wire logic link_sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic wp_n,
	// array check
	input wire logic [11:0] array_addr,
	input wire logic partition_region_locked,
	input wire logic array_write_allowed,
	// status and partition update
	input wire logic [7:0] status_byte_zero,
	input wire logic [7:0] status_byte_one,
	input wire logic busy_flag,
	input wire logic partition_write_go,
	input wire logic [23:0] partition_write_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// legacy mode, latch set and idle: only the block-protect field decides
	wire logic ready = !status_byte_one[7] && status_byte_zero[1] && !busy_flag;
	chk_zero_bits: assert property (status_byte_zero[6:4] == 3'h0)
		else $error("unused status bits set");
	chk_busy_mirror: assert property ({status_byte_zero[0], status_byte_one[0]} == {2{busy_flag}})
		else $error("busy bit differs from busy flag");
	chk_busy_span: assert property ($rose(busy_flag) |-> busy_flag [*8])
		else $error("write cycle ended early");
	chk_latch_needed: assert property (array_write_allowed |-> status_byte_zero[1] && !busy_flag)
		else $error("array write allowed without latch");
	chk_full_block: assert property (ready && status_byte_zero[3:2] == 2'h3 |-> !array_write_allowed)
		else $error("array open with full block protect");
	chk_quarter_gate: assert property (ready && status_byte_zero[3:2] == 2'h1 |->
		array_write_allowed == (array_addr < 12'hc00))
		else $error("upper quarter gate wrong");
	chk_no_region: assert property (ready && status_byte_zero[3:2] == 2'h0 |-> array_write_allowed)
		else $error("legacy array closed with no protection");
	chk_frozen_kept: assert property (status_byte_one[5] |=> status_byte_one[5] && $stable(status_byte_one[7]))
		else $error("frozen config changed");
	chk_latch_done: assert property ($fell(busy_flag) |-> !status_byte_zero[1])
		else $error("write latch left set after write");
	chk_go_gated: assert property (partition_write_go |-> $fell(busy_flag) && status_byte_one[4])
		else $error("partition update outside a finished gated write");
	chk_go_single: assert property (partition_write_go |=> !partition_write_go)
		else $error("partition update pulse too long");
	cover property (partition_write_go);
	cover property ($fell(busy_flag) && status_byte_one[5]);
	cover property (!wp_n && status_byte_zero[7] && !cs_n);
	cover property ($rose(status_byte_zero[1]));
endmodule : wp_ctrl_properties

bind wp_ctrl wp_ctrl_properties #(.WRITE_CYCLES(WRITE_CYCLES)) props (.mclk, .rstn, .link_sck,
	.cs_n, .si, .wp_n, .array_addr, .partition_region_locked, .array_write_allowed,
	.status_byte_zero, .status_byte_one, .busy_flag, .partition_write_go, .partition_write_data);

// ===== spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
	// link pins
	output logic link_sck,
	output logic cs_n,
	output logic si
);
	initial begin
		link_sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// msb first from bit 31; the clock stands low between frames
	task automatic frame(input logic [31:0] d, input int n);
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = d[31 - i];
			#62.5 link_sck = 1'b1;
			#62.5 link_sck = 1'b0;
		end
		si = ~si;
		#62.5 cs_n = 1'b1;
		// deselect gap well above the 4 mclk the core needs
		#100;
	endtask : frame
endmodule : spi_host_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic wp_n = 1'b1;
	logic [11:0] array_addr = 12'h0;
	logic locked = 1'b0;
	wire link_sck, cs_n, si, allowed, busy_flag, go;
	wire [7:0] sb0, sb1;
	wire [23:0] pdata;
	logic [7:0] n_go = 8'h00;
	int n_fail = 0;
	int n_checks = 0;
	logic [12:0] lim [4] = '{13'h1000, 13'h0c00, 13'h0800, 13'h0};
	logic [11:0] addrs [5] = '{12'h000, 12'h7ff, 12'h800, 12'hc00, 12'hfff};
	always #4 mclk = ~mclk;
	spi_host_model host (.link_sck(link_sck), .cs_n(cs_n), .si(si));
	wp_ctrl #(.WRITE_CYCLES(20)) dut (.mclk(mclk), .rstn(rstn), .link_sck(link_sck),
		.cs_n(cs_n), .si(si), .wp_n(wp_n), .array_addr(array_addr),
		.partition_region_locked(locked), .array_write_allowed(allowed),
		.status_byte_zero(sb0), .status_byte_one(sb1), .busy_flag(busy_flag),
		.partition_write_go(go), .partition_write_data(pdata));
	// go is a one-cycle pulse, so it is counted rather than looked at between frames
	always @(posedge mclk) begin
		if (go === 1'b1)
			n_go <= n_go + 8'h01;
	end
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic settle();
		for (int i = 0; i < 100 && busy_flag !== 1'b0; i++)
			@(posedge mclk);
		@(posedge mclk);
		#1;
	endtask : settle
	task automatic cmd(input logic [31:0] d, input int n);
		@(posedge mclk);
		#1;
		host.frame(d, n);
		settle();
	endtask : cmd
	task automatic wr(input logic [15:0] v, input int n);
		cmd({8'h06, 24'h0}, 8);
		cmd({8'h01, v, 8'h0}, n);
	endtask : wr
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		// the whole run takes about 90 us; this stays under 100k mclk cycles
		#600000;
		n_fail++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge mclk);
		#1 rstn = 1'b1;
		repeat (3) @(posedge mclk);
		check("status0", 8'h00, sb0);
		check("status1", 8'h00, sb1);
		locked = 1'b1;
		cmd({8'h06, 24'h0}, 8);
		check("latch set", 8'h02, sb0);
		check("partitions ignored", 8'h01, {7'h0, allowed});
		cmd({8'h04, 24'h0}, 8);
		check("latch clear", 8'h00, sb0);
		for (int b = 0; b < 4; b++) begin
			wr({4'h0, b[1:0], 10'h0}, 16);
			check("bp field", {4'h0, b[1:0], 2'b00}, sb0);
			cmd({8'h06, 24'h0}, 8);
			foreach (addrs[i]) begin
				array_addr = addrs[i];
				#1 check("array gate", {7'h0, addrs[i] < lim[b]}, {7'h0, allowed});
			end
		end
		wr(16'h8000, 16);
		check("pin enable", 8'h80, sb0);
		wp_n = 1'b0;
		wr(16'h8400, 16);
		check("protected write", 8'h82, sb0);
		fork
			cmd({8'h01, 8'h84, 16'h0}, 16);
			#1000 wp_n = 1'b1;
		join
		check("pin high once", 8'h84, sb0);
		wp_n = 1'b0;
		cmd({8'h06, 24'h0}, 8);
		cmd({8'h07, 24'h0}, 8);
		cmd({8'h37, 24'haa40d2}, 32);
		check("freeze refused", 8'h10, sb1);
		cmd({8'h04, 24'h0}, 8);
		check("clear under pin", 8'h84, sb0);
		wp_n = 1'b1;
		wr(16'h0000, 16);
		wp_n = 1'b0;
		wr(16'h0400, 16);
		check("pin ignored", 8'h04, sb0);
		cmd({8'h06, 24'h0}, 8);
		cmd({8'h37, 24'haa40d2}, 31);
		check("short freeze", 8'h10, sb1);
		cmd({8'h7c, 24'h0}, 8);
		check("soft reset", 8'h04, sb0);
		check("soft reset", 8'h00, sb1);
		wr(16'h0480, 24);
		check("mode select", 8'h80, sb1);
		cmd({8'h06, 24'h0}, 8);
		cmd({8'h07, 24'h0}, 8);
		check("partition latch", 8'h90, sb1);
		cmd({8'h32, 24'h123456}, 32);
		check("partition data", 24'h123456, pdata);
		check("partition latch kept", 8'h90, sb1);
		check("latch used up", 8'h04, sb0);
		cmd({8'h06, 24'h0}, 8);
		cmd({8'h34, 24'h0a1b2c}, 32);
		cmd({8'h32, 24'h654321}, 32);
		check("boundary data", 24'h0a1b2c, pdata);
		check("partition pulses", 24'h000002, {16'h0, n_go});
		cmd({8'h06, 24'h0}, 8);
		@(posedge mclk);
		#1 host.frame({8'h37, 24'haa40d2}, 32);
		check("freeze busy", 8'h01, {7'h0, busy_flag});
		settle();
		check("frozen", 8'ha0, sb1);
		check("freeze keeps bits", 8'h04, sb0);
		wr(16'h0800, 24);
		check("bp writable", 8'h08, sb0);
		check("mode fixed", 8'ha0, sb1);
		cmd({8'h06, 24'h0}, 8);
		cmd({8'h07, 24'h0}, 8);
		@(posedge mclk);
		#1 host.frame({8'h37, 24'haa40d2}, 32);
		check("refreeze", 8'h00, {7'h0, busy_flag});
		cmd({8'h0a, 24'h0}, 8);
		check("partition latch off", 8'ha0, sb1);
		cmd({8'h06, 24'h0}, 8);
		check("enhanced locked", 8'h00, {7'h0, allowed});
		locked = 1'b0;
		#1 check("enhanced free", 8'h01, {7'h0, allowed});
		complete_run();
	end
endmodule : testbench
